// File: rtl/pcer_pkg.sv
package pcer_pkg;

   localparam logic [7:0] CHR_CR    = 8'h0d;
   localparam logic [7:0] CHR_BANG  = 8'h21;
   localparam logic [7:0] CHR_ZERO  = 8'h30;

   // echo buffer geometry
   localparam int         BUF_DEPTH = 16;
   localparam int         IDX_W     = 6;
   localparam int         CNT_W     = 5;

   // numeric error codes
   localparam logic [3:0] CODE_BAD_CHAN = 4'h1;
   localparam logic [3:0] CODE_SYNTAX   = 4'h3;
   localparam logic [3:0] CODE_UNSUIT   = 4'h4;
   localparam logic [3:0] CODE_LINE     = 4'h9;

   // address select command is bang plus two hex digits
   localparam logic [CNT_W-1:0] ADDR_CMD_LEN = 5'h03;
   localparam logic [7:0]       ADDR_NONE    = 8'h00;

   // text messages, right justified in a fixed width vector
   localparam int         STR_W       = 8 * 44;
   localparam logic [STR_W-1:0] STR_UNREC   = "Error, Unrecognized Command: ";
   localparam logic [STR_W-1:0] STR_PARTIAL = "Error, Command not fully recognized: ";
   localparam logic [STR_W-1:0] STR_ADDR    = "Error, Address command must be CR terminated";
   localparam logic [IDX_W-1:0] LEN_UNREC   = 6'h1d;
   localparam logic [IDX_W-1:0] LEN_PARTIAL = 6'h25;
   localparam logic [IDX_W-1:0] LEN_ADDR    = 6'h2c;
   localparam logic [IDX_W-1:0] LEN_CODE    = 6'h01;

   typedef enum logic [2:0] {
      VRD_OK,
      VRD_BAD_CHAN,
      VRD_SYNTAX,
      VRD_UNSUIT,
      VRD_UNREC,
      VRD_PARTIAL
   } pcer_verdict_t;

   typedef enum logic [2:0] {
      MSG_NONE,
      MSG_CODE,
      MSG_UNREC,
      MSG_PARTIAL,
      MSG_ADDR
   } pcer_msg_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       parity_err;
      logic       framing_err;
   } pcer_rx_t;

   typedef struct packed {
      logic          valid;
      pcer_verdict_t verdict;
   } pcer_vrd_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } pcer_tx_t;

endpackage : pcer_pkg

// File: rtl/pcer_msg_rom.sv
`timescale 1ns/1ps
`default_nettype none

module pcer_msg_rom
   import pcer_pkg::*;
(
   input  wire pcer_msg_t        kind_in,  // message selected
   input  wire logic [IDX_W-1:0] idx_in,   // character index
   input  wire logic [3:0]       code_in,  // numeric code
   output logic [7:0]            chr_out,  // character at index
   output logic [IDX_W-1:0]      len_out   // text length
);

   function automatic logic [7:0] pick(input logic [STR_W-1:0] s,
                                       input logic [IDX_W-1:0] len,
                                       input logic [IDX_W-1:0] idx);
      logic [IDX_W-1:0] pos;
      pos = len - idx - 6'h01;
      return s[{pos, 3'h0} +: 8];
   endfunction : pick

   wire logic [7:0] code_chr = CHR_ZERO + {4'h0, code_in};

   assign chr_out = (kind_in == MSG_CODE)    ? code_chr :
                    (kind_in == MSG_UNREC)   ? pick(STR_UNREC, LEN_UNREC, idx_in) :
                    (kind_in == MSG_PARTIAL) ? pick(STR_PARTIAL, LEN_PARTIAL, idx_in) :
                    (kind_in == MSG_ADDR)    ? pick(STR_ADDR, LEN_ADDR, idx_in) :
                    CHR_CR;
   assign len_out = (kind_in == MSG_CODE)    ? LEN_CODE :
                    (kind_in == MSG_UNREC)   ? LEN_UNREC :
                    (kind_in == MSG_PARTIAL) ? LEN_PARTIAL :
                    (kind_in == MSG_ADDR)    ? LEN_ADDR :
                    6'h00;

endmodule : pcer_msg_rom

`default_nettype wire

// File: rtl/pcer_reporter.sv
`timescale 1ns/1ps
`default_nettype none

module pcer_reporter
   import pcer_pkg::*;
(
   input  wire logic       core_clk_in,  // 40 MHz clock
   input  wire logic       rst_in,       // sync reset, high
   input  wire pcer_rx_t   rx_in,        // received characters
   input  wire logic [7:0] pod_addr_in,  // own address, 00 = none
   output pcer_tx_t        cmd_req_out,  // command ready for handlers
   input  wire pcer_vrd_t  verdict_in,   // handler verdict
   output pcer_tx_t        tx_out,       // reply characters
   input  wire logic       tx_ready_in,  // transmitter takes char
   output logic            tx_oe_n_out,  // driver enable, low drives
   output logic            selected_out  // unit is selected
);

   typedef enum logic [2:0] {
      ST_COLLECT,
      ST_WAIT_VERDICT,
      ST_TEXT,
      ST_ECHO,
      ST_CR
   } pcer_state_t;

   function automatic logic [4:0] hex_val(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39) begin
         return {1'b1, c[3:0]};
      end else if ((c >= 8'h41 && c <= 8'h46) ||
                   (c >= 8'h61 && c <= 8'h66)) begin
         return {1'b1, c[3:0] + 4'h9};
      end
      return 5'h00;
   endfunction : hex_val

   pcer_state_t      state_reg, state_next;
   pcer_msg_t        msg_reg, msg_next;
   logic [3:0]       code_reg, code_next;
   logic [IDX_W-1:0] idx_reg, idx_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [7:0]       buf_reg [BUF_DEPTH];
   logic             fault_reg;
   logic             sel_reg, sel_next;
   logic             req_reg;
   logic [7:0]       tx_data_reg;
   logic             drive_reg;

   wire logic        tx_take   = drive_reg && tx_ready_in;
   wire logic        rx_char   = rx_in.valid && (state_reg == ST_COLLECT);
   wire logic        rx_bad    = rx_in.parity_err || rx_in.framing_err;
   wire logic        rx_cr     = rx_char && (rx_in.data == CHR_CR);
   wire logic        fault_now = fault_reg || (rx_char && rx_bad);
   wire logic        is_addr   = (cnt_reg != 5'h00) && (buf_reg[0] == CHR_BANG);
   wire logic [4:0]  hex_hi    = hex_val(buf_reg[1]);
   wire logic [4:0]  hex_lo    = hex_val(buf_reg[2]);
   // both digits must have arrived; stale chars would pass otherwise
   wire logic        addr_hex  = hex_hi[4] && hex_lo[4] &&
                                 (cnt_reg >= ADDR_CMD_LEN);
   wire logic [7:0]  addr_val  = {hex_hi[3:0], hex_lo[3:0]};
   wire logic        addr_mine = addr_hex && (addr_val == pod_addr_in);
   // non-addressed mode answers everything except address selects with two hex digits
   wire logic        answering = sel_reg || (pod_addr_in == ADDR_NONE);
   wire logic        buf_room  = cnt_reg < CNT_W'(BUF_DEPTH);

   logic [7:0]       rom_chr;
   logic [IDX_W-1:0] msg_len;

   pcer_msg_rom u_rom (
      .kind_in (msg_next),
      .idx_in  (idx_next),
      .code_in (code_next),
      .chr_out (rom_chr),
      .len_out ()
   );

   // length of the message currently being sent
   pcer_msg_rom u_len (
      .kind_in (msg_reg),
      .idx_in  (6'h00),
      .code_in (code_reg),
      .chr_out (),
      .len_out (msg_len)
   );

   wire logic echo_wanted = (msg_reg == MSG_UNREC) ||
                            (msg_reg == MSG_PARTIAL);
   wire logic text_last   = (idx_reg + 6'h01) == msg_len;
   wire logic echo_last   = (idx_reg + 6'h01) == {1'b0, cnt_reg};
   wire logic [7:0] echo_chr    = buf_reg[idx_next[3:0]];

   wire logic [7:0] chr_next = (state_next == ST_TEXT) ? rom_chr :
                               (state_next == ST_ECHO) ? echo_chr :
                               CHR_CR;

   always_comb begin
      state_next = state_reg;
      msg_next   = msg_reg;
      code_next  = code_reg;
      idx_next   = idx_reg;
      sel_next   = sel_reg;
      case (state_reg)
         ST_COLLECT: begin
            if (rx_cr) begin
               idx_next = 6'h00;
               if (is_addr && addr_hex) begin
                  sel_next = addr_mine;
                  if (addr_mine && cnt_reg != ADDR_CMD_LEN) begin
                     msg_next   = MSG_ADDR;
                     state_next = ST_TEXT;
                  end else if (addr_mine && fault_now) begin
                     msg_next   = MSG_CODE;
                     code_next  = CODE_LINE;
                     state_next = ST_TEXT;
                  end
               end else if (!answering) begin
                  state_next = ST_COLLECT;
               end else if (fault_now) begin
                  msg_next   = MSG_CODE;
                  code_next  = CODE_LINE;
                  state_next = ST_TEXT;
               end else if (is_addr) begin
                  msg_next   = MSG_CODE;
                  code_next  = CODE_SYNTAX;
                  state_next = ST_TEXT;
               end else begin
                  state_next = ST_WAIT_VERDICT;
               end
            end
         end
         ST_WAIT_VERDICT: begin
            if (verdict_in.valid) begin
               idx_next   = 6'h00;
               state_next = ST_TEXT;
               msg_next   = MSG_CODE;
               case (verdict_in.verdict)
                  VRD_BAD_CHAN: code_next = CODE_BAD_CHAN;
                  VRD_SYNTAX:   code_next = CODE_SYNTAX;
                  VRD_UNSUIT:   code_next = CODE_UNSUIT;
                  VRD_UNREC:    msg_next  = MSG_UNREC;
                  VRD_PARTIAL:  msg_next  = MSG_PARTIAL;
                  default: begin
                     // handler sends the normal reply itself
                     msg_next   = MSG_NONE;
                     state_next = ST_COLLECT;
                  end
               endcase
            end
         end
         ST_TEXT: begin
            if (tx_take) begin
               idx_next = idx_reg + 6'h01;
               if (text_last) begin
                  idx_next   = 6'h00;
                  state_next = (echo_wanted && cnt_reg != 5'h00) ?
                               ST_ECHO : ST_CR;
               end
            end
         end
         ST_ECHO: begin
            if (tx_take) begin
               idx_next = idx_reg + 6'h01;
               if (echo_last) begin
                  idx_next   = 6'h00;
                  state_next = ST_CR;
               end
            end
         end
         ST_CR: begin
            if (tx_take) begin
               msg_next   = MSG_NONE;
               state_next = ST_COLLECT;
            end
         end
         default: state_next = ST_COLLECT;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state_reg <= ST_COLLECT;
         msg_reg   <= MSG_NONE;
         code_reg  <= 4'h0;
         idx_reg   <= 6'h00;
         sel_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         msg_reg   <= msg_next;
         code_reg  <= code_next;
         idx_reg   <= idx_next;
         sel_reg   <= sel_next;
      end
   end

   // count survives the CR so the handler and the echo still see it
   wire logic cmd_end = (state_next == ST_COLLECT) &&
                        (rx_cr || (state_reg != ST_COLLECT));

   // command buffer; chars past the depth are dropped from the echo
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cnt_reg   <= 5'h00;
         fault_reg <= 1'b0;
      end else if (cmd_end) begin
         cnt_reg   <= 5'h00;
         fault_reg <= 1'b0;
      end else if (rx_char) begin
         if (buf_room && !rx_cr) begin
            cnt_reg <= cnt_reg + 5'h01;
         end
         fault_reg <= fault_now;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rx_char && !rx_cr && buf_room) begin
         buf_reg[cnt_reg[3:0]] <= rx_in.data;
      end
   end

   // buffer kept until the reply ends, so collection waits meanwhile
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         req_reg     <= 1'b0;
         tx_data_reg <= CHR_CR;
         drive_reg   <= 1'b0;
      end else begin
         req_reg     <= (state_reg == ST_COLLECT) &&
                        (state_next == ST_WAIT_VERDICT);
         tx_data_reg <= chr_next;
         drive_reg   <= (state_next == ST_TEXT) ||
                        (state_next == ST_ECHO) ||
                        (state_next == ST_CR);
      end
   end

   assign cmd_req_out.valid = req_reg;
   assign cmd_req_out.data  = {3'h0, cnt_reg};
   assign tx_out.valid      = drive_reg;
   assign tx_out.data       = tx_data_reg;
   assign tx_oe_n_out       = !drive_reg;
   assign selected_out      = sel_reg;

endmodule : pcer_reporter

`default_nettype wire

// File: testbench/pcer_reporter_props.sv
`timescale 1ns/1ps
`default_nettype none

module pcer_reporter_props
   import pcer_pkg::*;
(
   input  wire logic       core_clk_in,  // clock
   input  wire logic       rst_in,       // sync reset
   input  wire pcer_rx_t   rx_in,        // received chars
   input  wire logic [7:0] pod_addr_in,  // own address
   input  wire pcer_tx_t   cmd_req_out,  // handler request
   input  wire pcer_vrd_t  verdict_in,   // handler verdict
   input  wire pcer_tx_t   tx_out,       // reply chars
   input  wire logic       tx_ready_in,  // reply char taken
   input  wire logic       tx_oe_n_out,  // driver enable
   input  wire logic       selected_out  // unit selected
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   // a verdict only counts while a request is open
   logic wait_reg;
   logic wait_next;
   logic take_w;
   assign wait_next = cmd_req_out.valid | (wait_reg & ~verdict_in.valid);
   assign take_w    = wait_reg & verdict_in.valid;
   always_ff @(posedge core_clk_in) begin
      wait_reg <= rst_in ? 1'b0 : wait_next;
   end

   oe_follows_a:
      assert property (tx_oe_n_out == !tx_out.valid)
      else $error("driver enable does not follow reply");
   reset_idle_a:
      assert property ($fell(rst_in) |-> tx_oe_n_out && !selected_out)
      else $error("driver or selection active after reset");
   bad_chan_a:
      assert property (take_w && verdict_in.verdict == VRD_BAD_CHAN
         |=> tx_out.valid && tx_out.data == (CHR_ZERO | CODE_BAD_CHAN))
      else $error("bad channel reply wrong");
   syntax_code_a:
      assert property (take_w && verdict_in.verdict == VRD_SYNTAX
         |=> tx_out.valid && tx_out.data == (CHR_ZERO | CODE_SYNTAX))
      else $error("syntax reply wrong");
   unsuit_code_a:
      assert property (take_w && verdict_in.verdict == VRD_UNSUIT
         |=> tx_out.valid && tx_out.data == (CHR_ZERO | CODE_UNSUIT))
      else $error("unsuitable channel reply wrong");
   text_start_a:
      assert property (take_w && verdict_in.verdict inside {VRD_UNREC,
         VRD_PARTIAL} |=> tx_out.valid && tx_out.data == 8'h45)
      else $error("text error does not start with E");
   ok_quiet_a:
      assert property (take_w && verdict_in.verdict == VRD_OK
         |=> !tx_out.valid [*2])
      else $error("reply sent for good command");
   tx_hold_a:
      assert property (tx_out.valid && !tx_ready_in
         |=> tx_out.valid && $stable(tx_out.data))
      else $error("reply char dropped before taken");
   req_cause_a:
      assert property (cmd_req_out.valid |-> !tx_out.valid
         && $past(rx_in.valid && rx_in.data == CHR_CR))
      else $error("request without command end");
   sel_cause_a:
      assert property ($changed(selected_out) |-> $past(rst_in)
         || $past(rx_in.valid && rx_in.data == CHR_CR))
      else $error("selection changed without command");
endmodule : pcer_reporter_props

bind pcer_reporter pcer_reporter_props u_props (.core_clk_in, .rst_in,
   .rx_in, .pod_addr_in, .cmd_req_out, .verdict_in, .tx_out, .tx_ready_in,
   .tx_oe_n_out, .selected_out);

`default_nettype wire

// File: testbench/pcer_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module pcer_host_model
   import pcer_pkg::*;
(
   input  wire logic     clk_in,     // clock
   input  wire pcer_tx_t tx_in,      // pod reply
   input  wire logic     oe_n_in,    // pod drives line
   input  wire logic     slow_in,    // stall reply
   output pcer_rx_t      rx_out,     // chars to pod
   output logic          ready_out   // reply char taken
);
   logic [7:0] got[$];
   logic [1:0] gap_reg;

   initial begin
      rx_out    = '0;
      ready_out = 1'b0;
      gap_reg   = 2'h0;
   end

   // listen only while the pod drives the pair
   always @(posedge clk_in) begin
      if (tx_in.valid && ready_out && !oe_n_in)
         got.push_back(tx_in.data);
      gap_reg   <= gap_reg + 2'h1;
      ready_out <= !oe_n_in && (!slow_in || gap_reg == 2'h3);
   end

   task automatic send(input string s, input int bad, input logic frm);
      for (int i = 0; i < s.len(); i++) begin
         @(posedge clk_in);
         rx_out <= '{1'b1, s[i], i == bad && !frm, i == bad && frm};
      end
      @(posedge clk_in);
      // idle line must not look like the last char
      rx_out.valid <= 1'b0;
      rx_out.data  <= ~rx_out.data;
   endtask : send
endmodule : pcer_host_model

`default_nettype wire

// File: testbench/tb_pcer_reporter.sv
`timescale 1ns/1ps
`default_nettype none

module tb_pcer_reporter;
   import pcer_pkg::*;
   logic       core_clk_in = 1'b0;
   logic       rst_in      = 1'b1;
   logic [7:0] pod_addr    = 8'h00;
   logic       slow        = 1'b0;
   pcer_vrd_t  vrd         = '0;
   pcer_rx_t   rx;
   pcer_tx_t   cmd_req;
   pcer_tx_t   tx;
   logic       tx_ready;
   logic       oe_n;
   logic       sel;
   int         fails    = 0;
   int         compares = 0;
   int         reqs     = 0;

   always #12.5 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) if (cmd_req.valid) reqs++;

   pcer_reporter u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
      .rx_in(rx), .pod_addr_in(pod_addr), .cmd_req_out(cmd_req),
      .verdict_in(vrd), .tx_out(tx), .tx_ready_in(tx_ready),
      .tx_oe_n_out(oe_n), .selected_out(sel));
   pcer_host_model u_host (.clk_in(core_clk_in), .tx_in(tx),
      .oe_n_in(oe_n), .slow_in(slow), .rx_out(rx), .ready_out(tx_ready));

   task automatic cmp_val(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask : cmp_val

   task automatic cmp_str(input string e);
      logic ok;
      ok = (u_host.got.size() == e.len());
      for (int i = 0; i < e.len() && ok; i++) ok = (u_host.got[i] === e[i]);
      compares++;
      if (!ok) begin
         fails++;
         $display("mismatch at %0t: reply text wrong, want %s", $time, e);
      end
      u_host.got.delete();
   endtask : cmp_str

   task automatic reply(input string e);
      int n;
      for (n = 0; n < 40 && !tx.valid; n++) @(posedge core_clk_in);
      for (n = 0; n < 400 && tx.valid; n++) @(posedge core_clk_in);
      cmp_str(e);
   endtask : reply

   task automatic give(input pcer_verdict_t v, input logic [7:0] len);
      int n;
      for (n = 0; n < 20 && !cmd_req.valid; n++) @(posedge core_clk_in);
      cmp_val(cmd_req.valid, 1'b1);
      cmp_val(cmd_req.data, len);
      vrd <= '{1'b1, v};
      @(posedge core_clk_in);
      vrd <= '0;
   endtask : give

   task automatic t_codes;
      pcer_verdict_t v[3] = '{VRD_BAD_CHAN, VRD_SYNTAX, VRD_UNSUIT};
      logic [3:0]    c[3] = '{CODE_BAD_CHAN, CODE_SYNTAX, CODE_UNSUIT};
      string         e;
      for (int i = 0; i < 3; i++) begin
         slow <= i[0];
         e = "0\015";
         e[0] = CHR_ZERO | c[i];
         u_host.send("O7+\015", -1, 1'b0);
         give(v[i], 8'h03);
         reply(e);
      end
      slow <= 1'b0;
   endtask : t_codes

   task automatic t_text;
      u_host.send("Zq\015", -1, 1'b0);
      give(VRD_UNREC, 8'h02);
      reply("Error, Unrecognized Command: Zq\015");
      u_host.send("Oq\015", -1, 1'b0);
      give(VRD_PARTIAL, 8'h02);
      reply("Error, Command not fully recognized: Oq\015");
      u_host.send("I\015", -1, 1'b0);
      give(VRD_OK, 8'h01);
      reply("");
   endtask : t_text

   task automatic t_fault;
      int r;
      for (int f = 0; f < 2; f++) begin
         r = reqs;
         u_host.send("O1+\015", 1, f[0]);
         reply("9\015");
         cmp_val(reqs - r, 8'h00);
      end
   endtask : t_fault

   task automatic t_addr;
      int r;
      pod_addr <= 8'h5a;
      r = reqs;
      u_host.send("O1\015", -1, 1'b0);
      reply("");
      cmp_val(reqs - r, 8'h00);
      u_host.send("!5a\015", -1, 1'b0);
      repeat (8) @(posedge core_clk_in);
      cmp_val(sel, 1'b1);
      u_host.got.delete();
      u_host.send("O1\015", -1, 1'b0);
      give(VRD_OK, 8'h02);
      u_host.send("!5ax\015", -1, 1'b0);
      reply("Error, Address command must be CR terminated\015");
      u_host.send("!33\015", -1, 1'b0);
      repeat (8) @(posedge core_clk_in);
      cmp_val(sel, 1'b0);
      pod_addr <= 8'h00;
      u_host.send("!x\015", -1, 1'b0);
      reply("3\015");
   endtask : t_addr

   task automatic close_out;
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   initial begin
      repeat (20000) @(posedge core_clk_in);
      fails++;
      close_out();
   end

   initial begin
      repeat (12) @(posedge core_clk_in);
      rst_in <= 1'b0;
      t_codes();
      t_text();
      t_fault();
      t_addr();
      close_out();
   end
endmodule : tb_pcer_reporter

`default_nettype wire
